// file: tmb_pkg.sv
// package of constants and types for the timer internal bus access bridge
package tmb_pkg;
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 32;
    localparam int          TO_W           = 16;
    // status codes returned on the internal peripheral bus
    localparam logic [1:0]  STS_OK         = 2'h0;
    localparam logic [1:0]  STS_ERR2       = 2'h2;
    localparam logic [1:0]  STS_TIMEOUT    = 2'h3;
    // address decode: legacy global window, register slots in it, and the pll ram window
    localparam logic [15:0] LEGACY_BASE    = 16'hf000;
    localparam logic [15:0] LEGACY_MASK    = 16'hf000;
    localparam logic [15:0] AUX_SRC_ADDR   = 16'hf010;
    localparam logic [15:0] EXT_CAP_ADDR   = 16'hf020;
    localparam logic [15:0] XPT_ADDR       = 16'hf030;
    localparam logic [15:0] PLL_RAM_BASE   = 16'h8000;
    localparam logic [15:0] PLL_RAM_MASK   = 16'he000;
    localparam int          PLL_RAM_AW     = 3;
    localparam int          PLL_RAM_DEPTH  = 8;
    // wait cycles of a slow (N>1) target
    localparam logic [3:0]  SLOW_WAIT      = 4'h3;
    // reset values
    localparam logic [31:0] AUX_SRC_RST    = 32'h0000_0000;
    localparam logic [31:0] EXT_CAP_RST    = 32'h0000_0000;
    localparam int          XPT_VALID_BIT  = 31;
    typedef enum logic [1:0] {TMB_IDLE, TMB_WAIT, TMB_DONE} tmb_state_t;
    typedef enum logic [1:0] {TMB_RUN, TMB_HALT, TMB_RESTORE} tmb_dbg_t;
endpackage : tmb_pkg

// file: tmb_seq_stage.sv
// single-entry sequencer request holding stage
`timescale 1ns/1ps
`default_nettype none
module tmb_seq_stage
    import tmb_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire logic              in_write,
    input  wire logic [ADDR_W-1:0] in_addr,
    input  wire logic [DATA_W-1:0] in_wdata,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic                   out_write,
    output logic [ADDR_W-1:0]      out_addr,
    output logic [DATA_W-1:0]      out_wdata
);
    logic              full_r,  full_nxt;
    logic              wr_r,    wr_nxt;
    logic [ADDR_W-1:0] addr_r,  addr_nxt;
    logic [DATA_W-1:0] data_r,  data_nxt;

    // only an empty stage takes a request, so one entry at most waits
    assign in_ready  = !full_r;
    assign out_valid = full_r;
    assign out_write = wr_r;
    assign out_addr  = addr_r;
    assign out_wdata = data_r;

    // load when empty, drain on acceptance
    always_comb begin
        full_nxt = full_r;
        wr_nxt   = wr_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        if (full_r && out_ready) begin
            full_nxt = 1'b0;
        end else if (!full_r && in_valid) begin
            full_nxt = 1'b1;
            wr_nxt   = in_write;
            addr_nxt = in_addr;
            data_nxt = in_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            full_r <= 1'b0;
            wr_r   <= 1'b0;
            addr_r <= '0;
            data_r <= '0;
        end else begin
            full_r <= full_nxt;
            wr_r   <= wr_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
        end
    end
endmodule : tmb_seq_stage
`default_nettype wire

// file: tmb_bridge.sv
// timer internal bus bridge: arbitration, error capture, legacy, timeout, debug restore
`timescale 1ns/1ps
`default_nettype none
module tmb_bridge
    import tmb_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    // host cpu/dma port
    input  wire logic              host_req,
    input  wire logic              host_write,
    input  wire logic [ADDR_W-1:0] host_addr,
    input  wire logic [DATA_W-1:0] host_wdata,
    output logic                   host_ack,
    output logic [DATA_W-1:0]      host_rdata,
    output logic [1:0]             host_status,
    // sequencer bus-master port
    input  wire logic              seq_valid,
    output logic                   seq_ready,
    input  wire logic              seq_write,
    input  wire logic [ADDR_W-1:0] seq_addr,
    input  wire logic [DATA_W-1:0] seq_wdata,
    output logic                   seq_ack,
    output logic [DATA_W-1:0]      seq_rdata,
    output logic [1:0]             seq_status,
    // configuration and status
    input  wire logic              cluster0_enable,
    input  wire logic              host_priority,
    input  wire logic [TO_W-1:0]   timeout_value,
    input  wire logic              timeout_mode_bit,
    input  wire logic              halt_req,
    output logic                   debug_mode,
    output logic                   irq_notification_err,
    output logic                   irq_notification_to,
    output logic [DATA_W-1:0]      bus_exception_capture_reg,
    output logic [DATA_W-1:0]      aux_input_source_reg,
    output logic [DATA_W-1:0]      external_capture_enable_reg
);
    logic              sq_valid, sq_ready, sq_write;
    logic [ADDR_W-1:0] sq_addr;
    logic [DATA_W-1:0] sq_wdata;

    tmb_seq_stage u_stage (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (seq_valid),
        .in_ready  (seq_ready),
        .in_write  (seq_write),
        .in_addr   (seq_addr),
        .in_wdata  (seq_wdata),
        .out_valid (sq_valid),
        .out_ready (sq_ready),
        .out_write (sq_write),
        .out_addr  (sq_addr),
        .out_wdata (sq_wdata)
    );

    tmb_state_t        st_r,     st_nxt;
    tmb_dbg_t          dbg_r,    dbg_nxt;
    logic              own_seq_r, own_seq_nxt;
    logic              wr_r,     wr_nxt;
    logic [ADDR_W-1:0] addr_r,   addr_nxt;
    logic [DATA_W-1:0] wdata_r,  wdata_nxt;
    logic [3:0]        wait_r,   wait_nxt;
    logic [TO_W-1:0]   to_cnt_r, to_cnt_nxt;
    logic [DATA_W-1:0] rdata_r,  rdata_nxt;
    logic [1:0]        sts_r,    sts_nxt;
    logic              hack_r,   hack_nxt;
    logic              sack_r,   sack_nxt;
    logic [DATA_W-1:0] xpt_r,    xpt_nxt;
    logic              irq_e_r,  irq_e_nxt;
    logic              irq_t_r,  irq_t_nxt;
    logic [DATA_W-1:0] aux_r,    aux_nxt;
    logic [DATA_W-1:0] ext_r,    ext_nxt;
    logic [DATA_W-1:0] ram_r   [PLL_RAM_DEPTH];
    logic [DATA_W-1:0] ram_nxt [PLL_RAM_DEPTH];
    logic [DATA_W-1:0] shadow_r, shadow_nxt;
    logic [PLL_RAM_AW-1:0] shidx_r, shidx_nxt;
    logic              shv_r,    shv_nxt;
    logic              host_pend;
    logic              grant_seq;

    // host request only counts while no answer is standing
    assign host_pend = host_req && !hack_r;
    // sequencer first unless software flips priority
    assign grant_seq = sq_valid && (!host_priority || !host_pend);
    assign sq_ready  = (st_r == TMB_IDLE) && (dbg_r != TMB_RESTORE) && grant_seq; // one access in flight

    assign host_ack    = hack_r;
    assign host_rdata  = rdata_r;
    assign host_status = sts_r;
    assign seq_ack     = sack_r;
    assign seq_rdata   = rdata_r;
    assign seq_status  = sts_r;
    assign debug_mode  = (dbg_r == TMB_HALT);
    assign irq_notification_err        = irq_e_r;
    assign irq_notification_to         = irq_t_r;
    assign bus_exception_capture_reg   = xpt_r;
    assign aux_input_source_reg        = aux_r;
    assign external_capture_enable_reg = ext_r;

    // access engine, targets, capture, timeout and debug restore
    always_comb begin
        logic                  is_ram;
        logic                  legacy;
        logic [PLL_RAM_AW-1:0] idx;
        logic [1:0]            sts;
        logic                  fin;
        is_ram = 1'b0;
        legacy = 1'b0;
        idx    = '0;
        sts    = STS_OK;
        fin    = 1'b0;
        st_nxt = st_r;       dbg_nxt = dbg_r;      own_seq_nxt = own_seq_r;
        wr_nxt = wr_r;       addr_nxt = addr_r;    wdata_nxt = wdata_r;
        wait_nxt = wait_r;   to_cnt_nxt = to_cnt_r;
        rdata_nxt = rdata_r; sts_nxt = sts_r;
        hack_nxt = 1'b0;     sack_nxt = 1'b0;
        xpt_nxt = xpt_r;     irq_e_nxt = irq_e_r;  irq_t_nxt = irq_t_r;
        aux_nxt = aux_r;     ext_nxt = ext_r;
        shadow_nxt = shadow_r;
        shidx_nxt = shidx_r;
        shv_nxt = shv_r;
        for (int i = 0; i < PLL_RAM_DEPTH; i++) begin
            ram_nxt[i] = ram_r[i];
        end
        // halt entry and exit; restore replays shadow into ram
        case (dbg_r)
            TMB_RUN: begin
                if (halt_req) dbg_nxt = TMB_HALT;
            end
            TMB_HALT: begin
                if (!halt_req) dbg_nxt = TMB_RESTORE;
            end
            TMB_RESTORE: begin
                if (st_r == TMB_IDLE) begin
                    // only a write pending at halt entry is replayed, else ram stays as it is
                    if (shv_r) begin
                        ram_nxt[shidx_r] = shadow_r; // debug writes to that word are lost
                    end
                    shv_nxt = 1'b0;
                    dbg_nxt = TMB_RUN;
                end
            end
            default: dbg_nxt = TMB_RUN;
        endcase
        case (st_r)
            TMB_IDLE: begin
                if (dbg_r != TMB_RESTORE && (sq_valid || host_pend)) begin
                    own_seq_nxt = grant_seq;
                    wr_nxt      = grant_seq ? sq_write : host_write;
                    addr_nxt    = grant_seq ? sq_addr  : host_addr;
                    wdata_nxt   = grant_seq ? sq_wdata : host_wdata;
                    to_cnt_nxt  = '0;
                    // ram targets are slow, all others answer at once
                    if (((grant_seq ? sq_addr : host_addr) & PLL_RAM_MASK) == PLL_RAM_BASE) begin
                        wait_nxt = SLOW_WAIT;
                        st_nxt   = TMB_WAIT;
                    end else begin
                        wait_nxt = 4'h0;
                        st_nxt   = TMB_DONE;
                    end
                end
            end
            TMB_WAIT: begin
                wait_nxt   = wait_r - 4'h1;
                to_cnt_nxt = to_cnt_r + 1'b1;
                if (wait_r == 4'h1) st_nxt = TMB_DONE;
                // stall watchdog only guards host accesses
                if (!own_seq_r && timeout_value != '0 && to_cnt_r == timeout_value) begin
                    irq_t_nxt = 1'b1; // observe mode reports only
                    if (timeout_mode_bit) begin
                        st_nxt   = TMB_IDLE; // abort mode
                        fin      = 1'b1;
                        sts      = STS_TIMEOUT;
                        hack_nxt = 1'b1;
                        sts_nxt  = STS_TIMEOUT;
                    end
                end
            end
            TMB_DONE: begin
                st_nxt    = TMB_IDLE;
                fin       = 1'b1;
                is_ram    = (addr_r & PLL_RAM_MASK) == PLL_RAM_BASE;
                legacy    = (addr_r & LEGACY_MASK) == LEGACY_BASE;
                idx       = addr_r[PLL_RAM_AW+1:2];
                rdata_nxt = '0;
                sts       = STS_OK; // correct accesses answer 0
                if (addr_r[1:0] != 2'h0) begin
                    sts = STS_ERR2; // misaligned is a genuine fault
                end else if (is_ram) begin
                    if (wr_r) begin
                        ram_nxt[idx] = wdata_r;
                        // track sequencer write in flight at halt entry
                        if (own_seq_r && dbg_r == TMB_RUN && halt_req) begin
                            shadow_nxt = wdata_r;
                            shidx_nxt  = idx;
                            shv_nxt    = 1'b1;
                        end else if (dbg_r == TMB_HALT && shidx_r == idx) begin
                            shadow_nxt = shadow_r; // debug write lost on restore
                        end
                    end else begin
                        rdata_nxt = ram_r[idx]; // reads never touch ram
                    end
                end else if (addr_r == AUX_SRC_ADDR || addr_r == EXT_CAP_ADDR) begin
                    if (wr_r) begin
                        if (addr_r == AUX_SRC_ADDR) aux_nxt = wdata_r;
                        else ext_nxt = wdata_r;
                        if (!cluster0_enable) sts = STS_ERR2;
                    end else if (cluster0_enable) begin
                        rdata_nxt = (addr_r == AUX_SRC_ADDR) ? aux_r : ext_r;
                    end else begin
                        rdata_nxt = '0;
                    end
                end else if (addr_r == XPT_ADDR) begin
                    if (!wr_r) begin
                        rdata_nxt = (legacy && !cluster0_enable) ? '0 : xpt_r;
                        xpt_nxt   = '0; // read clears and re-arms
                    end
                end
                sts_nxt  = sts;
                hack_nxt = !own_seq_r;
                sack_nxt = own_seq_r;
            end
            default: st_nxt = TMB_IDLE;
        endcase
        // first faulted access is captured; later ones leave it
        if (fin && sts != STS_OK) begin
            if (sts == STS_ERR2) irq_e_nxt = 1'b1;
            if (!xpt_r[XPT_VALID_BIT]) begin
                xpt_nxt = {1'b1, 11'h0, sts, 2'h0, addr_r};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= TMB_IDLE;     dbg_r <= TMB_RUN;  own_seq_r <= 1'b0;
            wr_r <= 1'b0;         addr_r <= '0;      wdata_r <= '0;
            wait_r <= 4'h0;       to_cnt_r <= '0;    rdata_r <= '0;
            sts_r <= STS_OK;      hack_r <= 1'b0;    sack_r <= 1'b0;
            xpt_r <= '0;          irq_e_r <= 1'b0;   irq_t_r <= 1'b0;
            aux_r <= AUX_SRC_RST; ext_r <= EXT_CAP_RST;
            shadow_r <= '0;       shidx_r <= '0;
            shv_r <= 1'b0;
            for (int i = 0; i < PLL_RAM_DEPTH; i++) begin
                ram_r[i] <= '0;
            end
        end else begin
            st_r <= st_nxt;       dbg_r <= dbg_nxt;  own_seq_r <= own_seq_nxt;
            wr_r <= wr_nxt;       addr_r <= addr_nxt; wdata_r <= wdata_nxt;
            wait_r <= wait_nxt;   to_cnt_r <= to_cnt_nxt; rdata_r <= rdata_nxt;
            sts_r <= sts_nxt;     hack_r <= hack_nxt; sack_r <= sack_nxt;
            xpt_r <= xpt_nxt;     irq_e_r <= irq_e_nxt; irq_t_r <= irq_t_nxt;
            aux_r <= aux_nxt;     ext_r <= ext_nxt;
            shadow_r <= shadow_nxt; shidx_r <= shidx_nxt;
            shv_r <= shv_nxt;
            for (int i = 0; i < PLL_RAM_DEPTH; i++) begin
                ram_r[i] <= ram_nxt[i];
            end
        end
    end
endmodule : tmb_bridge
`default_nettype wire

// file: tmb_chk.sv
// port checker for the timer internal bus bridge
`timescale 1ns/1ps
`default_nettype none
module tmb_chk
    import tmb_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              host_write,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic              host_ack,
    input wire logic [DATA_W-1:0] host_rdata,
    input wire logic [1:0]        host_status,
    input wire logic              seq_valid,
    input wire logic              seq_ready,
    input wire logic              seq_ack,
    input wire logic              cluster0_enable,
    input wire logic [TO_W-1:0]   timeout_value,
    input wire logic              timeout_mode_bit,
    input wire logic              halt_req,
    input wire logic              debug_mode,
    input wire logic              irq_notification_err,
    input wire logic [DATA_W-1:0] bus_exception_capture_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // one engine serves both ports, so acks never coincide
    property p_one_ack; !(host_ack && seq_ack); endproperty
    a_one_ack: assert property (p_one_ack) else $error("both acks high");
    property p_err_flag; host_ack && host_status == STS_ERR2 |-> ##[0:1] irq_notification_err; endproperty
    a_err_flag: assert property (p_err_flag) else $error("notify not set");
    // sticky until reset
    property p_err_stick; irq_notification_err |=> irq_notification_err; endproperty
    a_err_stick: assert property (p_err_stick) else $error("notify dropped");
    property p_cap_hold; $past(bus_exception_capture_reg[31]) && bus_exception_capture_reg[31] |-> $stable(bus_exception_capture_reg); endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capture overwritten");
    property p_leg_wr; host_ack && host_write && host_addr == AUX_SRC_ADDR && !cluster0_enable |-> host_status == STS_ERR2; endproperty
    a_leg_wr: assert property (p_leg_wr) else $error("legacy write status");
    property p_leg_rd; host_ack && !host_write && host_addr == AUX_SRC_ADDR && !cluster0_enable |-> host_rdata == '0; endproperty
    a_leg_rd: assert property (p_leg_rd) else $error("legacy read not zero");
    // an abort needs both a count and abort mode
    property p_abort; host_ack && host_status == STS_TIMEOUT |-> timeout_mode_bit && timeout_value != '0; endproperty
    a_abort: assert property (p_abort) else $error("abort in observe mode");
    property p_halt; $rose(halt_req) |-> ##[1:4] debug_mode; endproperty
    a_halt: assert property (p_halt) else $error("no debug entry");
    property p_seq_done; seq_valid && seq_ready |-> ##[3:60] seq_ack; endproperty
    a_seq_done: assert property (p_seq_done) else $error("sequencer request lost");
endmodule : tmb_chk
`default_nettype wire

// file: tmb_seq_model.sv
// sequencer channel model on the bus-master port
`timescale 1ns/1ps
`default_nettype none
module tmb_seq_model
    import tmb_pkg::*;
(
    input  wire logic              clk,
    output logic                   seq_valid,
    input  wire logic              seq_ready,
    output logic                   seq_write,
    output logic [ADDR_W-1:0]      seq_addr,
    output logic [DATA_W-1:0]      seq_wdata,
    input  wire logic              seq_ack,
    input  wire logic [DATA_W-1:0] seq_rdata
);
    initial begin
        seq_valid = 1'b0;
        seq_write = 1'b0;
        seq_addr = '1;
        seq_wdata = '1;
    end
    // single thread, word aligned fast or slow targets, one access in flight
    task automatic issue(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                         output logic [DATA_W-1:0] rd, output logic ok);
        int n;
        @(posedge clk);
        seq_valid <= 1'b1;
        seq_write <= w;
        seq_addr <= a;
        seq_wdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (seq_ready !== 1'b1 && n < 60);
        ok = (seq_ready === 1'b1);
        // released at the accepting edge; lines show the inverse so stale values cannot pass
        seq_valid <= 1'b0;
        seq_addr <= ~a;
        seq_wdata <= ~d;
        n = 0;
        // answer taken at the edge that samples seq_ack high
        do begin
            @(posedge clk);
            n++;
        end while (seq_ack !== 1'b1 && n < 60);
        ok = ok && (seq_ack === 1'b1);
        rd = (seq_ack === 1'b1) ? seq_rdata : ~d;
    endtask : issue
endmodule : tmb_seq_model
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the timer internal bus bridge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import tmb_pkg::*;
    localparam logic [DATA_W-1:0] E0 = {30'h0, STS_OK};
    localparam logic [DATA_W-1:0] E2 = {30'h0, STS_ERR2};
    localparam logic [DATA_W-1:0] E3 = {30'h0, STS_TIMEOUT};
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              host_req = 1'b0;
    logic              host_write = 1'b0;
    logic [ADDR_W-1:0] host_addr = '0;
    logic [DATA_W-1:0] host_wdata = '0;
    logic              cluster0_enable = 1'b1;
    logic              host_priority = 1'b0;
    logic [TO_W-1:0]   timeout_value = '0;
    logic              timeout_mode_bit = 1'b0;
    logic              halt_req = 1'b0;
    logic              host_ack, seq_valid, seq_ready, seq_write, seq_ack, debug_mode;
    logic              irq_notification_err, irq_notification_to;
    logic [1:0]        host_status, seq_status;
    logic [ADDR_W-1:0] seq_addr;
    logic [DATA_W-1:0] host_rdata, seq_wdata, seq_rdata, bus_exception_capture_reg;
    logic [DATA_W-1:0] aux_input_source_reg, external_capture_enable_reg, rd, st, sd;
    int                failures = 0;
    int                n_checks = 0;
    always #10 clk = ~clk;
    tmb_bridge dut (.clk, .rst, .host_req, .host_write, .host_addr, .host_wdata, .host_ack, .host_rdata,
        .host_status, .seq_valid, .seq_ready, .seq_write, .seq_addr, .seq_wdata, .seq_ack, .seq_rdata,
        .seq_status, .cluster0_enable, .host_priority, .timeout_value, .timeout_mode_bit, .halt_req,
        .debug_mode, .irq_notification_err, .irq_notification_to, .bus_exception_capture_reg,
        .aux_input_source_reg, .external_capture_enable_reg);
    tmb_seq_model seq (.clk, .seq_valid, .seq_ready, .seq_write, .seq_addr, .seq_wdata, .seq_ack, .seq_rdata);
    task automatic report_and_stop();
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input string nm, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // request held up to the edge that samples host_ack high, answer taken there
    task automatic host(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        @(posedge clk);
        host_req <= 1'b1;
        host_write <= w;
        host_addr <= a;
        host_wdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (host_ack !== 1'b1 && n < 60);
        if (host_ack !== 1'b1) begin
            failures++;
            $display("[ERR] host_ack expected 1 seen %b", host_ack);
            report_and_stop();
        end
        host_req <= 1'b0;
        rd = host_rdata;
        st = {30'h0, host_status};
    endtask : host
    // sequencer access through the model; a lost handshake ends the run
    task automatic seq_op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic ok;
        seq.issue(w, a, d, sd, ok);
        if (!ok) begin
            failures++;
            $display("[ERR] seq_ack expected 1 seen %b", seq_ack);
            report_and_stop();
        end
    endtask : seq_op
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        host(1'b1, AUX_SRC_ADDR, 32'h0000_00a5);
        check("aux wr st", E0, st);
        host(1'b1, PLL_RAM_BASE, 32'h1234_5678);
        host(1'b0, PLL_RAM_BASE, '0);
        check("ram rd", 32'h1234_5678, rd);
        check("ram st", E0, st);
        cluster0_enable <= 1'b0;
        host(1'b1, AUX_SRC_ADDR, 32'h0000_005a);
        check("legacy wr st", E2, st);
        host(1'b0, AUX_SRC_ADDR, '0);
        check("legacy rd", '0, rd);
        check("irq err", 32'h1, {31'h0, irq_notification_err});
        check("capture", 32'h8008_f010, bus_exception_capture_reg);
        host(1'b1, EXT_CAP_ADDR, 32'h0000_0003);
        check("ext wr st", E2, st);
        cluster0_enable <= 1'b1;
        host(1'b0, AUX_SRC_ADDR, '0);
        check("aux kept", 32'h0000_005a, rd);
        check("aux reg", 32'h0000_005a, aux_input_source_reg);
        check("ext reg", 32'h0000_0003, external_capture_enable_reg);
        check("capture held", 32'h8008_f010, bus_exception_capture_reg);
        host(1'b0, XPT_ADDR, '0);
        check("capture rd", 32'h8008_f010, rd);
        @(posedge clk);
        check("capture clr", '0, bus_exception_capture_reg);
        host(1'b1, PLL_RAM_BASE + 16'h1, 32'h0);
        check("misaligned st", E2, st);
        host(1'b0, XPT_ADDR, '0);
        check("recapture", 32'h8008_8001, rd);
        // observe mode first, then abort mode
        timeout_value <= 16'h0001;
        host(1'b0, PLL_RAM_BASE, '0);
        check("observe st", E0, st);
        check("observe rd", 32'h1234_5678, rd);
        timeout_mode_bit <= 1'b1;
        host(1'b0, PLL_RAM_BASE, '0);
        check("abort st", E3, st);
        check("irq to", 32'h1, {31'h0, irq_notification_to});
        // recovery by reset after an abort
        timeout_value <= '0;
        timeout_mode_bit <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // sequencer and host collide one cycle apart, both priorities; one sequencer thread only
        for (int p = 0; p < 2; p++) begin
            host_priority <= p[0];
            fork
                seq_op(1'b1, PLL_RAM_BASE + 16'h4, 32'hcafe_0001 + p);
                begin
                    @(posedge clk);
                    host(1'b0, PLL_RAM_BASE + 16'h4, '0);
                end
            join
            check("priority", 32'hcafe_0001, rd);
        end
        seq_op(1'b0, PLL_RAM_BASE + 16'h4, '0);
        check("seq rd", 32'hcafe_0002, sd);
        check("seq st", E0, {30'h0, seq_status});
        // a word written before halt must survive the restore when no sequencer write was pending
        host(1'b1, PLL_RAM_BASE, 32'h0000_00c3);
        check("ram0 wr st", E0, st);
        halt_req <= 1'b1;
        repeat (4) @(posedge clk);
        check("debug on", 32'h1, {31'h0, debug_mode});
        host(1'b0, PLL_RAM_BASE + 16'h4, '0);
        check("debug rd", 32'hcafe_0002, rd);
        halt_req <= 1'b0;
        for (int n = 0; n < 50 && debug_mode !== 1'b0; n++) begin
            @(posedge clk);
        end
        check("debug off", '0, {31'h0, debug_mode});
        host(1'b0, PLL_RAM_BASE + 16'h4, '0);
        check("ram after", 32'hcafe_0002, rd);
        host(1'b0, PLL_RAM_BASE, '0);
        check("restore kept", 32'h0000_00c3, rd);
        report_and_stop();
    end
endmodule : tb_top
bind tmb_bridge tmb_chk chk (.clk, .rst, .host_write, .host_addr, .host_ack, .host_rdata, .host_status,
    .seq_valid, .seq_ready, .seq_ack, .cluster0_enable, .timeout_value, .timeout_mode_bit, .halt_req,
    .debug_mode, .irq_notification_err, .bus_exception_capture_reg);
`default_nettype wire
